// [src/bld_pkg.sv]
// package: register map, reset values and timing constants for battery level detect control
package bld_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ctrl_addr = 4'h0;
    localparam logic [3:0] detect_addr = 4'h4;
    localparam logic [3:0] status_addr = 4'h8;
    localparam int heavy_load_pos = 0;
    localparam int fast_clock_pos = 1;
    localparam int low_volt_pos = 2;
    localparam int load_done_pos = 3;
    localparam int shared_pos = 0;
    localparam int settled_pos = 1;
    localparam int hold_pos = 2;
    localparam int recover_pos = 3;
    localparam int strobe_over_pos = 4;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int clk_mhz = 200;
    localparam int settle_us = 100;
    localparam int settle_cycles = settle_us * clk_mhz;
    localparam int hold_ms = 600;
    localparam int hold_cycles = hold_ms * 1000 * clk_mhz;
    localparam int recover_ms = 1000;
    localparam int recover_cycles = recover_ms * 1000 * clk_mhz;
    localparam int strobe_max_ms = 10;
    localparam int strobe_max_cycles = strobe_max_ms * 1000 * clk_mhz;
endpackage

// [src/time_counter.sv]
// module: down counter that reports when a loaded time has elapsed
module time_counter #(
    parameter int width = 28
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic start,
    input wire logic stop,
    input wire logic [width-1:0] load_value,
    output logic busy,
    output logic done
);
    logic [width-1:0] count_r;
    logic done_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_r <= '0;
            done_r <= 1'b0;
        end else if (clk_en) begin
            if (stop) begin
                count_r <= '0;
                done_r <= 1'b0;
            end else if (start) begin
                count_r <= load_value;
                done_r <= 1'b0;
            end else if (count_r != '0) begin
                count_r <= count_r - 1'b1;
                if (count_r == {{(width-1){1'b0}}, 1'b1}) begin
                    done_r <= 1'b1;
                end
            end
        end
    end

    assign busy = (count_r != '0);
    assign done = done_r;
endmodule

// [src/battery_level_detect_control.sv]
// module: battery level detector control with heavy load protection, axi4-lite registers
// Behaviour
// R1: result counts as valid only after detector has been on 100 us.
// R2: slow clock, mode-started: software reads result one instruction after setting mode.
// R3: slow clock, strobe-started: software holds strobe 100 us, clears it, then reads.
// R4: fast clock variant keeps heavy load mode set at least 0.6 s.
// R5: fast clock, mode-started: software waits 0.6 s before reading result.
// R6: fast clock, strobe-started: software sets mode, strobes 100 us, clears, reads.
// R7: strobe and result share one bit: write drives strobe, read returns result.
// R8: software uses plain writes for the strobe, never read-modify-write.
// R9: low-voltage variant: wait 1 s or pulse strobe before leaving protection mode.
// R10: standard and fast variants return to normal mode without a software sequence.
// R11: strobe set during protection mode is cleared by software within 10 ms.
module battery_level_detect_control #(
    parameter int settle_count = bld_pkg::settle_cycles,
    parameter int hold_count = bld_pkg::hold_cycles,
    parameter int recover_count = bld_pkg::recover_cycles,
    parameter int strobe_max_count = bld_pkg::strobe_max_cycles
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comparator_in,
    output logic detector_on,
    output logic protection_mode
);
    localparam int cw = 28;

    // ------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------
    logic cmp_meta_r;
    logic cmp_sync_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
        end else if (clk_en) begin
            cmp_meta_r <= comparator_in;
            cmp_sync_r <= cmp_meta_r;
        end
    end

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic aw_held_r;
    logic w_held_r;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic wr_go;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign wr_go = aw_held_r && w_held_r && !bvalid_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= bld_pkg::resp_okay;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (aw_addr_r == bld_pkg::ctrl_addr || aw_addr_r == bld_pkg::detect_addr)
                    ? bld_pkg::resp_okay : bld_pkg::resp_slverr;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    logic wr_ctrl;
    logic wr_detect;
    assign wr_ctrl = wr_go && aw_addr_r == bld_pkg::ctrl_addr && w_strb_r[0];
    assign wr_detect = wr_go && aw_addr_r == bld_pkg::detect_addr && w_strb_r[0];

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    logic mode_req_r;
    logic fast_clock_r;
    logic low_volt_r;
    logic detect_strobe_bit_r;
    logic load_done_pulse;
    logic hold_busy;
    logic settle_busy;
    logic settle_done;
    logic settled_r;
    logic recover_busy;
    logic recover_done;
    logic strobe_busy;
    logic strobe_done;
    logic strobe_over_r;
    logic battery_low_result_r;
    logic heavy_load_mode_bit;
    logic strobe_seen_r;

    assign load_done_pulse = wr_ctrl && w_data_r[bld_pkg::load_done_pos];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_req_r <= bld_pkg::ctrl_reset[bld_pkg::heavy_load_pos];
            fast_clock_r <= bld_pkg::ctrl_reset[bld_pkg::fast_clock_pos];
            low_volt_r <= bld_pkg::ctrl_reset[bld_pkg::low_volt_pos];
        end else if (clk_en) begin
            if (wr_ctrl) begin
                mode_req_r <= w_data_r[bld_pkg::heavy_load_pos];
                fast_clock_r <= w_data_r[bld_pkg::fast_clock_pos];
                low_volt_r <= w_data_r[bld_pkg::low_volt_pos];
            end
        end
    end

    // write-only strobe; reads of this bit show the result instead
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            detect_strobe_bit_r <= 1'b0;
        end else if (clk_en && wr_detect) begin
            detect_strobe_bit_r <= w_data_r[bld_pkg::shared_pos]; // R7
        end
    end

    // fast clock: mode stays set while hold timer runs
    logic mode_rise;
    assign mode_rise = wr_ctrl && w_data_r[bld_pkg::heavy_load_pos] && !mode_req_r;

    time_counter #(.width(cw)) u_hold (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .start(mode_rise && w_data_r[bld_pkg::fast_clock_pos]),
        .stop(1'b0),
        .load_value(cw'(hold_count)),
        .busy(hold_busy),
        .done()
    );

    // low-voltage recovery: protection persists until 1 s or a strobe pulse
    logic recover_pend_r;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            recover_pend_r <= 1'b0;
            strobe_seen_r <= 1'b0;
        end else if (clk_en) begin
            if (load_done_pulse && low_volt_r) begin
                recover_pend_r <= 1'b1;
                strobe_seen_r <= 1'b0;
            end else if (recover_pend_r) begin
                if (detect_strobe_bit_r && settled_r) begin
                    strobe_seen_r <= 1'b1;
                end
                if (recover_done || (strobe_seen_r && !detect_strobe_bit_r)) begin
                    recover_pend_r <= 1'b0; // R9
                end
            end
        end
    end

    time_counter #(.width(cw)) u_recover (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .start(load_done_pulse && low_volt_r),
        .stop(1'b0),
        .load_value(cw'(recover_count)),
        .busy(recover_busy),
        .done(recover_done)
    );

    // standard variant leaves protection as soon as software clears the mode
    assign heavy_load_mode_bit = mode_req_r || hold_busy || (low_volt_r && recover_pend_r); // R4 R10
    assign protection_mode = heavy_load_mode_bit;

    // ------------------------------------------------------------
    // detector power and settle
    // ------------------------------------------------------------
    assign detector_on = heavy_load_mode_bit || detect_strobe_bit_r;

    logic det_on_d_r;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            det_on_d_r <= 1'b0;
        end else if (clk_en) begin
            det_on_d_r <= detector_on;
        end
    end

    time_counter #(.width(cw)) u_settle (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .start(detector_on && !det_on_d_r),
        .stop(!detector_on),
        .load_value(cw'(settle_count)),
        .busy(settle_busy),
        .done(settle_done)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            settled_r <= 1'b0;
            battery_low_result_r <= 1'b0;
        end else if (clk_en) begin
            settled_r <= settle_done && detector_on; // R1
            if (settle_done && detector_on) begin
                battery_low_result_r <= cmp_sync_r; // R1
            end
        end
    end

    // strobe left on too long in protection mode
    time_counter #(.width(cw)) u_strobe (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .start(wr_detect && w_data_r[bld_pkg::shared_pos] && heavy_load_mode_bit),
        // the strobe register is still low on the write edge: let the start win there
        .stop(!detect_strobe_bit_r && !wr_detect),
        .load_value(cw'(strobe_max_count)),
        .busy(strobe_busy),
        .done(strobe_done)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strobe_over_r <= 1'b0;
        end else if (clk_en) begin
            if (strobe_done) begin
                strobe_over_r <= 1'b1; // R11
            end else if (wr_ctrl) begin
                strobe_over_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    assign s_axi_arready = !rvalid_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= bld_pkg::resp_okay;
        end else if (clk_en) begin
            if (s_axi_arvalid && !rvalid_r) begin
                rvalid_r <= 1'b1;
                rresp_r <= bld_pkg::resp_okay;
                rdata_r <= 32'h0000_0000;
                unique case (s_axi_araddr)
                    bld_pkg::ctrl_addr: begin
                        rdata_r[bld_pkg::heavy_load_pos] <= heavy_load_mode_bit;
                        rdata_r[bld_pkg::fast_clock_pos] <= fast_clock_r;
                        rdata_r[bld_pkg::low_volt_pos] <= low_volt_r;
                    end
                    bld_pkg::detect_addr: begin
                        rdata_r[bld_pkg::shared_pos] <= battery_low_result_r; // R7
                    end
                    bld_pkg::status_addr: begin
                        rdata_r[bld_pkg::shared_pos] <= battery_low_result_r;
                        rdata_r[bld_pkg::settled_pos] <= settled_r;
                        rdata_r[bld_pkg::hold_pos] <= hold_busy;
                        rdata_r[bld_pkg::recover_pos] <= recover_pend_r;
                        rdata_r[bld_pkg::strobe_over_pos] <= strobe_over_r;
                    end
                    default: begin
                        rresp_r <= bld_pkg::resp_slverr;
                    end
                endcase
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence strobe_write_one;
        wr_detect && w_data_r[bld_pkg::shared_pos];
    endsequence

    a_strobe_follows_write: assert property (@(posedge clk) disable iff (sys_rst) // R7
        strobe_write_one and clk_en |=> detect_strobe_bit_r)
        else $error("strobe not set by write");

    a_result_needs_settle: assert property (@(posedge clk) disable iff (sys_rst) // R1
        settled_r |-> $past(detector_on) && !settle_busy)
        else $error("result flagged before settle time");

    a_detector_off_clears: assert property (@(posedge clk) disable iff (sys_rst) // R1
        clk_en && !detector_on |=> !settled_r)
        else $error("settled flag stayed with detector off");

    a_fast_mode_holds: assert property (@(posedge clk) disable iff (sys_rst) // R4
        hold_busy |-> heavy_load_mode_bit)
        else $error("heavy load mode dropped during hold");

    a_fast_mode_starts: assert property (@(posedge clk) disable iff (sys_rst) // R4
        clk_en && mode_rise && w_data_r[bld_pkg::fast_clock_pos] |=> hold_busy)
        else $error("hold timer did not start");

    a_normal_returns: assert property (@(posedge clk) disable iff (sys_rst) // R10
        clk_en && wr_ctrl && !w_data_r[bld_pkg::heavy_load_pos]
        && !w_data_r[bld_pkg::low_volt_pos] && !hold_busy |=> !protection_mode)
        else $error("protection mode stuck on standard variant");

    a_shared_read_result: assert property (@(posedge clk) disable iff (sys_rst) // R7
        clk_en && s_axi_arvalid && !rvalid_r && s_axi_araddr == bld_pkg::detect_addr
        |=> rdata_r[bld_pkg::shared_pos] == $past(battery_low_result_r))
        else $error("shared bit read did not return result");

    a_strobe_overtime: assert property (@(posedge clk) disable iff (sys_rst) // R11
        clk_en && strobe_done |=> strobe_over_r)
        else $error("overlong strobe not flagged");

    a_write_response: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && wr_go |=> s_axi_bvalid)
        else $error("write response missing");
endmodule

// [test/test_battery_level_detect_control.sv]
// testbench: self-checking register and timing scenarios for battery level detect control
module test_battery_level_detect_control;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic comparator_in = 1'b0;
    logic detector_on;
    logic protection_mode;
    int fail_count = 0;
    int compares = 0;
    logic c_r;
    logic m_r;

    battery_level_detect_control #(
        .settle_count(8),
        .hold_count(20),
        .recover_count(30),
        .strobe_max_count(16)
    ) dut_u (
        .clk, .sys_rst, .clk_en,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .comparator_in, .detector_on, .protection_mode
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] exp_ctrl(input logic mode, input logic fast, input logic lv);
        return {29'h0, lv, fast, mode};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st,
                      input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic wrd(input logic [3:0] a, input logic [31:0] d);
        wr(a, d, 4'hf, bld_pkg::resp_okay);
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp,
                        input logic [1:0] er);
        logic [31:0] d;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk(32'(s_axi_rresp), 32'(er));
        chk(d & mask, exp);
    endtask

    task automatic done(input string name);
        $display("test %s finished, compares=%0d", name, compares);
    endtask

    task automatic summarize;
        $display("counts: compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hbd362aba));
        cyc(5);
        sys_rst <= 1'b0;
        rchk(bld_pkg::ctrl_addr, 32'hffff_ffff, bld_pkg::ctrl_reset, bld_pkg::resp_okay);
        rchk(bld_pkg::status_addr, 32'h1f, 32'h0, bld_pkg::resp_okay);
        chk(32'(detector_on), 32'h0);
        chk(32'(protection_mode), 32'h0);
        done("reset");

        // unmapped place and a write whose low byte lane is off
        wr(4'hc, 32'h1, 4'hf, bld_pkg::resp_slverr);
        rchk(4'hc, 32'hffff_ffff, 32'h0, bld_pkg::resp_slverr);
        wr(bld_pkg::ctrl_addr, 32'h1, 4'he, bld_pkg::resp_okay);
        rchk(bld_pkg::ctrl_addr, 32'hf, 32'h0, bld_pkg::resp_okay);
        done("refusals");

        // strobe-started detection: early read is not settled yet
        @(posedge clk);
        comparator_in <= 1'b1;
        cyc(4);
        wrd(bld_pkg::detect_addr, 32'h1);
        chk(32'(detector_on), 32'h1);
        rchk(bld_pkg::status_addr, 32'h3, 32'h0, bld_pkg::resp_okay);
        cyc(20);
        rchk(bld_pkg::detect_addr, 32'h1, 32'h1, bld_pkg::resp_okay);
        rchk(bld_pkg::status_addr, 32'h12, 32'h2, bld_pkg::resp_okay);
        wrd(bld_pkg::detect_addr, 32'h0);
        @(posedge clk);
        comparator_in <= 1'b0;
        cyc(20);
        rchk(bld_pkg::detect_addr, 32'h1, 32'h1, bld_pkg::resp_okay);
        chk(32'(detector_on), 32'h0);
        done("strobe detect");

        // fast variant holds the mode bit after software clears it
        wrd(bld_pkg::ctrl_addr, exp_ctrl(1'b1, 1'b1, 1'b0));
        wrd(bld_pkg::ctrl_addr, exp_ctrl(1'b0, 1'b1, 1'b0));
        rchk(bld_pkg::ctrl_addr, 32'hf, exp_ctrl(1'b1, 1'b1, 1'b0), bld_pkg::resp_okay);
        chk(32'(protection_mode), 32'h1);
        // frozen clock enable must keep the hold timer where it is
        clk_en <= 1'b0;
        cyc(40);
        clk_en <= 1'b1;
        chk(32'(protection_mode), 32'h1);
        rchk(bld_pkg::status_addr, 32'h4, 32'h4, bld_pkg::resp_okay);
        cyc(40);
        rchk(bld_pkg::ctrl_addr, 32'hf, exp_ctrl(1'b0, 1'b1, 1'b0), bld_pkg::resp_okay);
        chk(32'(protection_mode), 32'h0);
        rchk(bld_pkg::detect_addr, 32'h1, 32'h0, bld_pkg::resp_okay);
        done("fast hold");

        // fast variant, strobe-started: mode first, then a strobe pulse
        wrd(bld_pkg::ctrl_addr, exp_ctrl(1'b1, 1'b1, 1'b0));
        comparator_in <= 1'b1;
        wrd(bld_pkg::detect_addr, 32'h1);
        cyc(8);
        wrd(bld_pkg::detect_addr, 32'h0);
        rchk(bld_pkg::detect_addr, 32'h1, 32'h1, bld_pkg::resp_okay);
        wrd(bld_pkg::ctrl_addr, exp_ctrl(1'b0, 1'b1, 1'b0));
        cyc(25);
        done("fast strobe");

        // standard variant leaves protection at once after a heavy load
        wrd(bld_pkg::ctrl_addr, exp_ctrl(1'b1, 1'b0, 1'b0));
        cyc(10);
        rchk(bld_pkg::detect_addr, 32'h1, 32'h1, bld_pkg::resp_okay);
        wrd(bld_pkg::ctrl_addr, 32'h9);
        wrd(bld_pkg::ctrl_addr, exp_ctrl(1'b0, 1'b0, 1'b0));
        chk(32'(protection_mode), 32'h0);
        rchk(bld_pkg::status_addr, 32'h8, 32'h0, bld_pkg::resp_okay);
        done("standard return");

        // low-voltage variant waits out the recovery time
        wrd(bld_pkg::ctrl_addr, exp_ctrl(1'b1, 1'b0, 1'b1));
        wrd(bld_pkg::ctrl_addr, 32'hd);
        wrd(bld_pkg::ctrl_addr, exp_ctrl(1'b0, 1'b0, 1'b1));
        chk(32'(protection_mode), 32'h1);
        rchk(bld_pkg::status_addr, 32'h8, 32'h8, bld_pkg::resp_okay);
        cyc(40);
        chk(32'(protection_mode), 32'h0);
        rchk(bld_pkg::status_addr, 32'h8, 32'h0, bld_pkg::resp_okay);
        done("low voltage recovery");

        // low-voltage variant leaves early after a settled strobe pulse
        wrd(bld_pkg::ctrl_addr, 32'hd);
        wrd(bld_pkg::ctrl_addr, exp_ctrl(1'b0, 1'b0, 1'b1));
        wrd(bld_pkg::detect_addr, 32'h1);
        cyc(8);
        wrd(bld_pkg::detect_addr, 32'h0);
        cyc(2);
        chk(32'(protection_mode), 32'h0);
        rchk(bld_pkg::status_addr, 32'h18, 32'h0, bld_pkg::resp_okay);
        done("low voltage strobe");

        // strobe left on too long during protection is flagged
        wrd(bld_pkg::ctrl_addr, exp_ctrl(1'b1, 1'b0, 1'b0));
        wrd(bld_pkg::detect_addr, 32'h1);
        cyc(25);
        rchk(bld_pkg::status_addr, 32'h10, 32'h10, bld_pkg::resp_okay);
        wrd(bld_pkg::detect_addr, 32'h0);
        wrd(bld_pkg::ctrl_addr, exp_ctrl(1'b0, 1'b0, 1'b0));
        rchk(bld_pkg::status_addr, 32'h10, 32'h0, bld_pkg::resp_okay);
        done("strobe overtime");

        // random comparator levels and mode settings
        for (int i = 0; i < 8; i++) begin
            c_r = 1'($urandom % 2);
            m_r = 1'($urandom % 2);
            @(posedge clk);
            comparator_in <= c_r;
            wrd(bld_pkg::ctrl_addr, exp_ctrl(m_r, 1'b0, 1'b0));
            rchk(bld_pkg::ctrl_addr, 32'hf, exp_ctrl(m_r, 1'b0, 1'b0), bld_pkg::resp_okay);
            chk(32'(protection_mode), 32'(m_r));
            wrd(bld_pkg::detect_addr, 32'h1);
            cyc(8 + int'($urandom % 4));
            wrd(bld_pkg::detect_addr, 32'h0);
            rchk(bld_pkg::detect_addr, 32'h1, 32'(c_r), bld_pkg::resp_okay);
        end
        wrd(bld_pkg::ctrl_addr, exp_ctrl(1'b0, 1'b0, 1'b0));
        done("random detect");
        summarize();
    end
endmodule
